// [verilog/gptu_pkg.sv]
// shared constants, types and register map of the general purpose timer unit
// Behaviour
// - core timer toggle latch inverts on every core overflow or underflow.
// - core latch can drive toggle output pin and clock either aux timer.
// - aux timer acts as capture or reload register and stops counting then.
// - capture-role aux timer copies core count on its own pin edge.
// - reload-role aux timer loads core on pin edge or selected latch transition.
// - opposite-edge reloads from both aux timers give continuous pwm waveform.
// - second module timers tick no faster than eight half clock periods.
// - second module has two up/down timers plus capture/reload register.
// - second core latch inverts on wrap and can clock second module timer.
// - second core timer wrap can reload it from capture/reload register.
// - capture pin edge latches second module timer, optional clear afterwards.
// - capture may instead trigger on core count input, direction input, or both.
// - five 16-bit timers, each independent or chained within its module.
// - first module modes timer, gated, counter, incremental; sixteen half periods minimum in timer and gated modes.
// - first module direction set by software, flipped by direction pin level.
// - incremental mode derives count and direction from quadrature pins.
package gptu_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TCL_NS        = CLK_PERIOD_NS / 2;
   localparam int G1_RES_TCL    = 16;
   localparam int G2_RES_TCL    = 8;
   localparam int G1_BASE_CYC   = (G1_RES_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int G2_BASE_CYC   = (G2_RES_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ************************************************************
   // timer indices
   // ************************************************************
   localparam int TW       = 16;
   localparam int NTMR     = 5;
   localparam int IX_AUXA  = 0;
   localparam int IX_CORE  = 1;
   localparam int IX_AUXB  = 2;
   localparam int IX_T5    = 3;
   localparam int IX_T6    = 4;
   localparam int NIRQ     = 6;
   localparam int IRQ_CAP  = 5;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_CTL0   = 8'h00;
   localparam logic [7:0] OFS_CNT0   = 8'h14;
   localparam logic [7:0] OFS_CAPTURE_RELOAD_REGISTER = 8'h28;
   localparam logic [7:0] OFS_ISTAT  = 8'h2c;
   localparam logic [7:0] OFS_IMASK  = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_INCR} gptu_mode_t;
   typedef enum logic [1:0] {ROLE_NONE, ROLE_CAPTURE, ROLE_RELOAD, ROLE_SPARE} gptu_role_t;

   typedef struct packed {
      logic [2:0]  pre;      // prescaler exponent
      logic        out_en;   // core latch onto pin
      logic [1:0]  cap_sel;  // capture source, second module
      logic        clr_cap;  // clear after capture
      logic        rl_ext;   // reload on pin edge
      logic        rl_fall;  // reload on latch fall
      logic        rl_rise;  // reload on latch rise
      gptu_role_t  role;
      logic        tclk;     // clocked by partner latch
      logic        glvl;     // active gate level / edge
      logic        run;
      logic        xdir;     // direction pin may flip
      logic        down;
      gptu_mode_t  mode;
   } gptu_ctl_t;

   localparam int          CTL_W    = $bits(gptu_ctl_t);
   localparam gptu_ctl_t   CTL_RST  = '0;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] PRE_RST  = 16'h0000;
   localparam logic [5:0]  IRQ_RST  = 6'h00;
endpackage : gptu_pkg

// [verilog/gptu_tmr.sv]
// one 16-bit up/down timer cell with load, clear and wrap detect
`timescale 1ns/1ps
module gptu_tmr #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_arst_n,
   // control
   input  wire logic         i_cnt_en,
   input  wire logic         i_up,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_load_val,
   input  wire logic         i_clr,
   // state
   output logic      [W-1:0] o_cnt,
   output logic              o_wrap
);
   logic [W-1:0] cnt_r;

   // wrap only when a count step passes an end of the range
   assign o_wrap = i_cnt_en && (i_up ? (&cnt_r) : (cnt_r == '0));
   assign o_cnt  = cnt_r;

   // load beats clear beats count, so a reload replaces the wrap value
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= '0;
      end else if (i_load) begin
         cnt_r <= i_load_val;
      end else if (i_clr) begin
         cnt_r <= '0;
      end else if (i_cnt_en) begin
         cnt_r <= i_up ? cnt_r + 1'b1 : cnt_r - 1'b1;
      end
   end
endmodule : gptu_tmr

// [verilog/gptu_top.sv]
// two-module general purpose timer unit with ahb-lite register slave
`timescale 1ns/1ps
module gptu_top (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_arst_n,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // timer pins, index 0 aux a, 1 core, 2 aux b
   input  wire logic [2:0]  i_timer_gate_count_input,
   input  wire logic [2:0]  i_timer_direction_input,
   input  wire logic        i_capture_input_pin,
   // outputs
   output logic             o_toggle_output_pin,
   output logic             o_irq
);
   // ************************************************************
   // declarations
   // ************************************************************
   gptu_pkg::gptu_ctl_t ctl_r [gptu_pkg::NTMR];
   logic [15:0]         cnt   [gptu_pkg::NTMR];
   logic [15:0]         ldv   [gptu_pkg::NTMR];
   logic [4:0]          wrap, en, up, load, clr;
   logic [4:0]          sw_ctl, sw_cnt;
   logic [15:0]         capture_reload_register_r, pre_cnt_r;
   logic [5:0]          istat_r, istat_nxt, imask_r;
   logic                core_latch_r, sec_latch_r;
   logic                core_rise, core_fall;
   logic [2:0]          rl_trig, cap_trig;
   logic                cap2_trig;
   logic [6:0]          pin_s1_r, pin_s2_r, pin_s3_r, pin_edge;
   logic                wr_pend_r, rd_pend_r;
   logic [7:0]          addr_r;
   logic [31:0]         rd_val;
   logic                take;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // bits 0..2 gate/count, 3..5 direction, 6 capture pin
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_s1_r <= 7'h00;
         pin_s2_r <= 7'h00;
         pin_s3_r <= 7'h00;
      end else begin
         pin_s1_r <= {i_capture_input_pin, i_timer_direction_input, i_timer_gate_count_input};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end
   assign pin_edge = pin_s2_r ^ pin_s3_r;  // edges seen after the second flop only

   // ************************************************************
   // prescaler
   // ************************************************************
   // one free-running counter serves every timer; ticks are masks of it
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pre_cnt_r <= gptu_pkg::PRE_RST;
      end else begin
         pre_cnt_r <= pre_cnt_r + 16'h0001;
      end
   end
   function automatic logic tick_at(input logic [15:0] pc, input int base, input logic [2:0] pre);
      logic [15:0] m;
      m = (16'(base) << pre) - 16'h0001;
      return (pc & m) == m;
   endfunction : tick_at

   // ************************************************************
   // latch transitions and triggers
   // ************************************************************
   assign core_rise = wrap[gptu_pkg::IX_CORE] & ~core_latch_r;
   assign core_fall = wrap[gptu_pkg::IX_CORE] & core_latch_r;

   // aux capture/reload triggers; index 1 unused
   always_comb begin
      rl_trig  = 3'b000;
      cap_trig = 3'b000;
      for (int i = 0; i < 3; i += 2) begin
         cap_trig[i] = (ctl_r[i].role == gptu_pkg::ROLE_CAPTURE) && pin_edge[i];
         rl_trig[i]  = (ctl_r[i].role == gptu_pkg::ROLE_RELOAD) &&
                       ((ctl_r[i].rl_ext && pin_edge[i]) ||
                        (ctl_r[i].rl_rise && core_rise) ||
                        (ctl_r[i].rl_fall && core_fall));
      end
   end

   // second module capture source: pin, or core count/direction inputs
   always_comb begin
      cap2_trig = 1'b0;
      if (ctl_r[gptu_pkg::IX_T5].role == gptu_pkg::ROLE_CAPTURE) begin
         if (ctl_r[gptu_pkg::IX_T5].cap_sel == 2'b00) begin
            cap2_trig = pin_edge[6];
         end else begin
            cap2_trig = (ctl_r[gptu_pkg::IX_T5].cap_sel[0] && pin_edge[1]) ||
                        (ctl_r[gptu_pkg::IX_T5].cap_sel[1] && pin_edge[4]);
         end
      end
   end

   // ************************************************************
   // count enables and directions
   // ************************************************************
   always_comb begin
      logic ev;
      logic gin;
      logic din;
      ev = 1'b0;
      gin = 1'b0;
      din = 1'b0;
      en = 5'b00000;
      up = 5'b00000;
      // first module
      for (int i = 0; i < 3; i++) begin
         gin = pin_s2_r[i];
         din = pin_s2_r[3+i];
         case (ctl_r[i].mode)
            gptu_pkg::MODE_TIMER:   ev = tick_at(pre_cnt_r, gptu_pkg::G1_BASE_CYC, ctl_r[i].pre);
            gptu_pkg::MODE_GATED:   ev = tick_at(pre_cnt_r, gptu_pkg::G1_BASE_CYC, ctl_r[i].pre) &&
                                         (gin == ctl_r[i].glvl);
            gptu_pkg::MODE_COUNTER: ev = pin_edge[i] && (gin == ctl_r[i].glvl);
            gptu_pkg::MODE_INCR:    ev = pin_edge[i] || pin_edge[3+i];
            default:                ev = 1'b0;
         endcase
         // aux timers chained to the core latch count its transitions
         if (i != gptu_pkg::IX_CORE && ctl_r[i].tclk) begin
            ev = wrap[gptu_pkg::IX_CORE];
         end
         // aux timers serving as capture/reload registers are frozen
         en[i] = ctl_r[i].run && ev &&
                 !(i != gptu_pkg::IX_CORE && ctl_r[i].role != gptu_pkg::ROLE_NONE);
         if (ctl_r[i].mode == gptu_pkg::MODE_INCR) begin
            up[i] = pin_edge[i] ? (gin != din) : (gin == din);
         end else begin
            up[i] = !(ctl_r[i].down ^ (ctl_r[i].xdir && din));
         end
      end
      // second module
      en[gptu_pkg::IX_T6] = ctl_r[gptu_pkg::IX_T6].run &&
                            tick_at(pre_cnt_r, gptu_pkg::G2_BASE_CYC, ctl_r[gptu_pkg::IX_T6].pre);
      en[gptu_pkg::IX_T5] = ctl_r[gptu_pkg::IX_T5].run &&
                            (ctl_r[gptu_pkg::IX_T5].tclk ? wrap[gptu_pkg::IX_T6] :
                             tick_at(pre_cnt_r, gptu_pkg::G2_BASE_CYC, ctl_r[gptu_pkg::IX_T5].pre));
      up[gptu_pkg::IX_T5] = !ctl_r[gptu_pkg::IX_T5].down;
      up[gptu_pkg::IX_T6] = !ctl_r[gptu_pkg::IX_T6].down;
   end

   // ************************************************************
   // loads and clears
   // ************************************************************
   // software writes take priority over every hardware load
   always_comb begin
      for (int i = 0; i < gptu_pkg::NTMR; i++) begin
         load[i] = sw_cnt[i];
         ldv[i]  = i_hwdata[15:0];
         clr[i]  = 1'b0;
      end
      for (int i = 0; i < 3; i += 2) begin
         if (!sw_cnt[i] && cap_trig[i]) begin
            load[i] = 1'b1;
            ldv[i]  = cnt[gptu_pkg::IX_CORE];
         end
      end
      // aux a wins if both reload in the same cycle
      if (!sw_cnt[gptu_pkg::IX_CORE] && (rl_trig[0] || rl_trig[2])) begin
         load[gptu_pkg::IX_CORE] = 1'b1;
         ldv[gptu_pkg::IX_CORE]  = rl_trig[0] ? cnt[gptu_pkg::IX_AUXA] : cnt[gptu_pkg::IX_AUXB];
      end
      if (!sw_cnt[gptu_pkg::IX_T6] && wrap[gptu_pkg::IX_T6] &&
          ctl_r[gptu_pkg::IX_T6].role == gptu_pkg::ROLE_RELOAD) begin
         load[gptu_pkg::IX_T6] = 1'b1;
         ldv[gptu_pkg::IX_T6]  = capture_reload_register_r;
      end
      clr[gptu_pkg::IX_T5] = cap2_trig && ctl_r[gptu_pkg::IX_T5].clr_cap;
   end

   // ************************************************************
   // timer cells
   // ************************************************************
   for (genvar g = 0; g < gptu_pkg::NTMR; g++) begin : g_tmr
      gptu_tmr #(.W(gptu_pkg::TW)) u_tmr (
         .i_mclk     (i_mclk),
         .i_arst_n   (i_arst_n),
         .i_cnt_en   (en[g]),
         .i_up       (up[g]),
         .i_load     (load[g]),
         .i_load_val (ldv[g]),
         .i_clr      (clr[g]),
         .o_cnt      (cnt[g]),
         .o_wrap     (wrap[g])
      );
   end

   // ************************************************************
   // toggle latches, capture register, output pin
   // ************************************************************
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         core_latch_r <= 1'b0;
         sec_latch_r  <= 1'b0;
      end else begin
         core_latch_r <= core_latch_r ^ wrap[gptu_pkg::IX_CORE];
         sec_latch_r  <= sec_latch_r ^ wrap[gptu_pkg::IX_T6];
      end
   end
   // a hardware capture wins over a software write in the same cycle
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         capture_reload_register_r <= gptu_pkg::CNT_RST;
      end else if (cap2_trig) begin
         capture_reload_register_r <= cnt[gptu_pkg::IX_T5];
      end else if (wr_pend_r && addr_r == gptu_pkg::OFS_CAPTURE_RELOAD_REGISTER) begin
         capture_reload_register_r <= i_hwdata[15:0];
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_toggle_output_pin <= 1'b0;
      end else begin
         o_toggle_output_pin <= ctl_r[gptu_pkg::IX_CORE].out_en & core_latch_r;
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************
   // a new event outranks a write-one clear in the same cycle
   always_comb begin
      istat_nxt = istat_r;
      if (wr_pend_r && addr_r == gptu_pkg::OFS_ISTAT) begin
         istat_nxt = istat_nxt & ~i_hwdata[5:0];
      end
      istat_nxt = istat_nxt | {cap2_trig, wrap[4:3], wrap[2:0] | cap_trig};
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         istat_r <= gptu_pkg::IRQ_RST;
         imask_r <= gptu_pkg::IRQ_RST;
         o_irq   <= 1'b0;
      end else begin
         istat_r <= istat_nxt;
         if (wr_pend_r && addr_r == gptu_pkg::OFS_IMASK) begin
            imask_r <= i_hwdata[5:0];
         end
         o_irq <= |(istat_nxt & imask_r);
      end
   end

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   // reads add one wait state so a write just before is already visible
   assign take = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'b010);

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_pend_r   <= 1'b0;
         rd_pend_r   <= 1'b0;
         addr_r      <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= 32'h0000_0000;
      end else begin
         wr_pend_r <= take && i_hwrite;
         rd_pend_r <= take && !i_hwrite;
         if (take) begin
            addr_r <= i_haddr[7:0];
         end
         o_hreadyout <= !(take && !i_hwrite);
         o_hresp     <= 1'b0;
         if (rd_pend_r) begin
            o_hrdata <= rd_val;
         end
      end
   end

   // write strobes per timer
   always_comb begin
      for (int i = 0; i < gptu_pkg::NTMR; i++) begin
         sw_ctl[i] = wr_pend_r && addr_r == gptu_pkg::OFS_CTL0 + 8'(4 * i);
         sw_cnt[i] = wr_pend_r && addr_r == gptu_pkg::OFS_CNT0 + 8'(4 * i);
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < gptu_pkg::NTMR; i++) begin
            ctl_r[i] <= gptu_pkg::CTL_RST;
         end
      end else begin
         for (int i = 0; i < gptu_pkg::NTMR; i++) begin
            if (sw_ctl[i]) begin
               ctl_r[i] <= gptu_pkg::gptu_ctl_t'(i_hwdata[gptu_pkg::CTL_W-1:0]);
            end
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      for (int i = 0; i < gptu_pkg::NTMR; i++) begin
         if (addr_r == gptu_pkg::OFS_CTL0 + 8'(4 * i)) begin
            rd_val = {{(32 - gptu_pkg::CTL_W){1'b0}}, ctl_r[i]};
         end
         if (addr_r == gptu_pkg::OFS_CNT0 + 8'(4 * i)) begin
            rd_val = {16'h0000, cnt[i]};
         end
      end
      case (addr_r)
         gptu_pkg::OFS_CAPTURE_RELOAD_REGISTER: rd_val = {16'h0000, capture_reload_register_r};
         gptu_pkg::OFS_ISTAT:  rd_val = {26'h0, istat_r};
         gptu_pkg::OFS_IMASK:  rd_val = {26'h0, imask_r};
         gptu_pkg::OFS_STATUS: rd_val = {30'h0, sec_latch_r, core_latch_r};
         default:              rd_val = rd_val;
      endcase
   end

   // ************************************************************
   // assertions
   // ************************************************************
   logic [3:0] g1_gap_r;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         g1_gap_r <= 4'hf;
      end else begin
         g1_gap_r <= en[gptu_pkg::IX_CORE] ? 4'h0 : (g1_gap_r == 4'hf ? g1_gap_r : g1_gap_r + 4'h1);
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   toggle_flip_a: assert property (wrap[1] |=> core_latch_r != $past(core_latch_r))
      else $error("core latch did not toggle on wrap");
   toggle_pin_a: assert property (ctl_r[1].out_en && $stable(ctl_r[1]) |=> o_toggle_output_pin == $past(core_latch_r))
      else $error("toggle pin does not follow latch");
   aux_stop_a: assert property (ctl_r[0].role != gptu_pkg::ROLE_NONE && !load[0] |=> cnt[0] == $past(cnt[0]))
      else $error("aux timer moved while in register role");
   aux_capture_a: assert property (cap_trig[0] && !sw_cnt[0] |=> cnt[0] == $past(cnt[1]))
      else $error("aux capture missed core count");
   core_reload_a: assert property (rl_trig[2] && !rl_trig[0] && !sw_cnt[1] |=> cnt[1] == $past(cnt[2]))
      else $error("core not reloaded from aux b");
   g2_res_a: assert property (en[4] |=> !en[4] [*3])
      else $error("second module ticks too fast");
   g1_res_a: assert property (en[1] && ctl_r[1].mode == gptu_pkg::MODE_TIMER && $stable(ctl_r[1])
                              |-> g1_gap_r >= 4'h7)
      else $error("first module ticks too fast");
   t6_reload_a: assert property (load[4] && !sw_cnt[4] |=> cnt[4] == $past(capture_reload_register_r))
      else $error("second core not reloaded");
   capture_reload_register_cap_a: assert property (cap2_trig |=> capture_reload_register_r == $past(cnt[3]) ##0 (!$past(clr[3]) || cnt[3] == 16'h0000))
      else $error("capture register missed count");
   irq_set_a: assert property (wrap[1] |=> istat_r[1] ##1 (!imask_r[1] || o_irq))
      else $error("core wrap flag or irq missing");
   pwm_alt_c: cover property (rl_trig[0] ##[1:500] rl_trig[2] ##[1:500] rl_trig[0]);
   cap2_c: cover property (cap2_trig && ctl_r[3].clr_cap);
   irq_c: cover property ($rose(o_irq));
endmodule : gptu_top

// [tb/gptu_pins.sv]
// far-side model: event, gate and capture pins toggled on request
`timescale 1ns/1ps
module gptu_pins (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_arst_n,
   // toggle requests, [2:0] gate/count pins, [3] capture pin, [4] aux a direction pin
   input  wire logic [4:0] i_tgl,
   // pins towards the unit
   output logic      [2:0] o_gate,
   output logic      [2:0] o_dir,
   output logic            o_cap
);
   // ************************************************************
   // pin levels
   // ************************************************************
   logic [4:0] lvl_r;
   // levels change only right after an edge, like a real driver
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lvl_r <= 5'h00;
      end else begin
         lvl_r <= lvl_r ^ i_tgl;
      end
   end
   // only the aux a direction pin moves; core and aux b keep software direction
   assign o_gate = lvl_r[2:0];
   assign o_dir  = {2'b00, lvl_r[4]};
   assign o_cap  = lvl_r[3];
endmodule : gptu_pins

// [tb/general_purpose_timer_unit_tb.sv]
// self-checking bench of the timer unit over ahb-lite
`timescale 1ns/1ps
module general_purpose_timer_unit_tb;
   logic        i_mclk   = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        hsel     = 1'b0;
   logic        hwrite   = 1'b0;
   logic [1:0]  htrans   = 2'h0;
   logic [31:0] haddr    = 32'h0;
   logic [31:0] hwdata   = 32'h0;
   logic [4:0]  preq     = 5'h00;
   logic [31:0] hrdata, rd;
   logic        hrdy, hresp, tog, irq, cap;
   logic [2:0]  gate, dir;
   int          fails = 0, cmp_count = 0, cyc = 0;

   always #5 i_mclk = ~i_mclk;

   gptu_pins i_pins (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_tgl(preq), .o_gate(gate), .o_dir(dir), .o_cap(cap));
   gptu_top i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(hresp), .i_timer_gate_count_input(gate), .i_timer_direction_input(dir),
      .i_capture_input_pin(cap), .o_toggle_output_pin(tog), .o_irq(irq));

   // ************************************************************
   // tasks
   // ************************************************************
   task complete_run;
      $display("fails %0d cmp_count %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one single word transfer; entered right after a rising edge
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   // one pin edge, then room for sync and edge detect
   task tg(input int i);
      preq[i] <= 1'b1;
      @(posedge i_mclk);
      preq[i] <= 1'b0;
      repeat (8) @(posedge i_mclk);
   endtask : tg

   // hang guard, tests need well under this
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         complete_run();
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      @(posedge i_mclk);
      rdc(8'h04, 32'h0);
      rdc(8'h3c, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // core wraps after two ticks of eight cycles
      ahb(1'b1, 8'h18, 32'hfffe);
      ahb(1'b1, 8'h04, 32'h8010);
      repeat (40) @(posedge i_mclk);
      rdc(8'h2c, 32'h2);
      rdc(8'h34, 32'h1);
      chk({31'h0, tog}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, 8'h30, 32'h2);
      repeat (2) @(posedge i_mclk);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b1, 8'h2c, 32'h2);
      repeat (2) @(posedge i_mclk);
      chk({31'h0, irq}, 32'h0);
      // aux a captures a stopped core on its own pin edge
      ahb(1'b1, 8'h04, 32'h8000);
      ahb(1'b1, 8'h18, 32'h1234);
      ahb(1'b1, 8'h00, 32'h80);
      tg(0);
      rdc(8'h14, 32'h1234);
      rdc(8'h2c, 32'h1);
      // capture register takes t5 then t5 clears
      ahb(1'b1, 8'h20, 32'hab);
      ahb(1'b1, 8'h0c, 32'h1080);
      tg(3);
      rdc(8'h28, 32'hab);
      rdc(8'h20, 32'h0);
      rdc(8'h2c, 32'h21);
      // aux b counts rising edges of its pin
      ahb(1'b1, 8'h08, 32'h32);
      repeat (6) tg(2);
      rdc(8'h1c, 32'h3);
      // direction pin high turns aux a counter to counting down
      ahb(1'b1, 8'h00, 32'h3a);
      tg(4);
      repeat (2) tg(0);
      rdc(8'h14, 32'h1233);
      // core counts rising pin edges; aux b reloads on latch fall, aux a on latch rise
      ahb(1'b1, 8'h14, 32'hfffe);
      ahb(1'b1, 8'h1c, 32'hfffd);
      ahb(1'b1, 8'h00, 32'h300);
      ahb(1'b1, 8'h08, 32'h500);
      ahb(1'b1, 8'h18, 32'hffff);
      ahb(1'b1, 8'h04, 32'h8032);
      repeat (2) tg(1);
      rdc(8'h18, 32'hfffd);
      repeat (6) tg(1);
      rdc(8'h18, 32'hfffe);
      rdc(8'h34, 32'h1);
      repeat (16) tg(1);
      rdc(8'h18, 32'hfffe);
      rdc(8'h34, 32'h0);
      // second core reloads from the capture register on every wrap
      ahb(1'b1, 8'h28, 32'hffff);
      ahb(1'b1, 8'h24, 32'hffff);
      ahb(1'b1, 8'h10, 32'h110);
      repeat (20) @(posedge i_mclk);
      rdc(8'h24, 32'hffff);
      rdc(8'h2c, 32'h33);
      complete_run();
   end
endmodule : general_purpose_timer_unit_tb
